// ### hw/ref_input_priority_regs.sv
// Reference input priority registers for inputs 7 to 10, two banks.
// Assumes a synchronous 8-bit register port on the system clock.
//
// What this block does
// - 4-bit fields, smaller nonzero ranks higher
// - zero field excludes input from selection
// - bank bit 0 selects primary path copy
// - bank bit 1 selects secondary path copy
// - 7/8 register: input 8 high nibble
// - 7/8 resets to 0x98, both copies
// - 9/10 resets to 0xBA, both copies
`timescale 1ns/100ps
module ref_input_priority_regs (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  output logic PATH_BANK_SELECT_O,
  output logic [3:0] PRIM_PRIO_SEVEN_O,
  output logic [3:0] PRIM_PRIO_EIGHT_O,
  output logic [3:0] PRIM_PRIO_NINE_O,
  output logic [3:0] PRIM_PRIO_TEN_O,
  output logic [3:0] SEC_PRIO_SEVEN_O,
  output logic [3:0] SEC_PRIO_EIGHT_O,
  output logic [3:0] SEC_PRIO_NINE_O,
  output logic [3:0] SEC_PRIO_TEN_O,
  output logic [3:0] PRIM_ENABLE_O,
  output logic [3:0] SEC_ENABLE_O,
  output logic [1:0] PRIM_BEST_O,
  output logic PRIM_BEST_VALID_O,
  output logic [1:0] SEC_BEST_O,
  output logic SEC_BEST_VALID_O
);
  import prio_regs_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [3:0] lo_field(input logic [7:0] r);
    lo_field = r[LO_FIELD_LSB +: FIELD_W];
  endfunction
  function automatic logic [3:0] hi_field(input logic [7:0] r);
    hi_field = r[HI_FIELD_LSB +: FIELD_W];
  endfunction
  // Index of best (smallest nonzero) of four fields, ties to lower index
  function automatic logic [2:0] best_of(input logic [15:0] f);
    logic [1:0] idx;
    logic [3:0] v;
    logic found;
    idx = 2'd0;
    v = 4'hF;
    found = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (f[k*4 +: 4] != PRIO_DISABLED && (!found || f[k*4 +: 4] < v)) begin
        idx = 2'(k);
        v = f[k*4 +: 4];
        found = 1'b1;
      end
    end
    best_of = {found, idx};
  endfunction

  // ==========================================================
  // Address decode
  logic [7:0] src_sel_r;
  logic [7:0] prim_78, prim_910, sec_78, sec_910;
  wire hit_78 = ADDR_I == ADDR_PRIO_7_8;
  wire hit_910 = ADDR_I == ADDR_PRIO_9_10;
  wire hit_src = ADDR_I == ADDR_SOURCE_SELECT;
  wire bank_sel = src_sel_r[BANK_SEL_BIT];
  wire prim_wr_78 = WR_I && hit_78 && !bank_sel;
  wire prim_wr_910 = WR_I && hit_910 && !bank_sel;
  wire sec_wr_78 = WR_I && hit_78 && bank_sel;
  wire sec_wr_910 = WR_I && hit_910 && bank_sel;
  wire [7:0] sel_78 = bank_sel ? sec_78 : prim_78;
  wire [7:0] sel_910 = bank_sel ? sec_910 : prim_910;
  wire [7:0] rd_mux = hit_78 ? sel_78 : hit_910 ? sel_910 : hit_src ? src_sel_r : UNMAPPED_READ;

  // ==========================================================
  // Source select holding the bank bit
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      src_sel_r <= RST_SOURCE_SELECT;
    end else if (WR_I && hit_src) begin
      src_sel_r <= WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      RDATA_O <= RST_READ_DATA;
    end else if (RD_I) begin
      RDATA_O <= rd_mux;
    end
  end

  // ==========================================================
  // Banks
  prio_bank u_prim (
    .clock_i(CLOCK_I),
    .srst_i(SRST_I),
    .wr_78_i(prim_wr_78),
    .wr_910_i(prim_wr_910),
    .wdata_i(WDATA_I),
    .prio_78_o(prim_78),
    .prio_910_o(prim_910)
  );
  prio_bank u_sec (
    .clock_i(CLOCK_I),
    .srst_i(SRST_I),
    .wr_78_i(sec_wr_78),
    .wr_910_i(sec_wr_910),
    .wdata_i(WDATA_I),
    .prio_78_o(sec_78),
    .prio_910_o(sec_910)
  );

  // ==========================================================
  // Field outputs
  assign PATH_BANK_SELECT_O = bank_sel;
  // input 7 low, input 8 high
  assign PRIM_PRIO_SEVEN_O = lo_field(prim_78);
  assign PRIM_PRIO_EIGHT_O = hi_field(prim_78);
  assign SEC_PRIO_SEVEN_O = lo_field(sec_78);
  assign SEC_PRIO_EIGHT_O = hi_field(sec_78);
  // input 9 low, input 10 high
  assign PRIM_PRIO_NINE_O = lo_field(prim_910);
  assign PRIM_PRIO_TEN_O = hi_field(prim_910);
  assign SEC_PRIO_NINE_O = lo_field(sec_910);
  assign SEC_PRIO_TEN_O = hi_field(sec_910);

  assign PRIM_ENABLE_O = {prim_910[7:4] != PRIO_DISABLED, prim_910[3:0] != PRIO_DISABLED,
                          prim_78[7:4] != PRIO_DISABLED, prim_78[3:0] != PRIO_DISABLED};
  assign SEC_ENABLE_O = {sec_910[7:4] != PRIO_DISABLED, sec_910[3:0] != PRIO_DISABLED,
                         sec_78[7:4] != PRIO_DISABLED, sec_78[3:0] != PRIO_DISABLED};

  wire [2:0] prim_best = best_of({prim_910, prim_78});
  wire [2:0] sec_best = best_of({sec_910, sec_78});
  assign PRIM_BEST_O = prim_best[1:0];
  assign PRIM_BEST_VALID_O = prim_best[2];
  assign SEC_BEST_O = sec_best[1:0];
  assign SEC_BEST_VALID_O = sec_best[2];

  // ==========================================================
  // Checks
  // Field picked by a best index, input 7 at index 0
  function automatic logic [3:0] field_at(input logic [15:0] f, input logic [1:0] i);
    field_at = f[{i, 2'b00} +: 4];
  endfunction
  wire [3:0] prim_best_val = field_at({prim_910, prim_78}, PRIM_BEST_O);
  wire [3:0] sec_best_val = field_at({sec_910, sec_78}, SEC_BEST_O);

  a_reset_78: assert property (@(posedge CLOCK_I)
    SRST_I |=> prim_78 == RST_PRIO_7_8 && sec_78 == RST_PRIO_7_8)
    else $error("7/8 reset value wrong");
  a_reset_910: assert property (@(posedge CLOCK_I)
    SRST_I |=> prim_910 == RST_PRIO_9_10 && sec_910 == RST_PRIO_9_10)
    else $error("9/10 reset value wrong");
  a_prim_write: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    prim_wr_78 |=> prim_78 == $past(WDATA_I) && $stable(sec_78))
    else $error("Primary write misrouted");
  a_prim_write_910: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    prim_wr_910 |=> prim_910 == $past(WDATA_I) && $stable(sec_910))
    else $error("Primary 9/10 write misrouted");
  a_sec_write: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    sec_wr_910 |=> sec_910 == $past(WDATA_I) && $stable(prim_910))
    else $error("Secondary write misrouted");
  a_sec_write_78: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    sec_wr_78 |=> sec_78 == $past(WDATA_I) && $stable(prim_78))
    else $error("Secondary 7/8 write misrouted");
  a_read_bank: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    RD_I && hit_78 |=> RDATA_O == ($past(bank_sel) ? $past(sec_78) : $past(prim_78)))
    else $error("Read from wrong bank");
  a_read_bank_910: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    RD_I && hit_910 |=> RDATA_O == ($past(bank_sel) ? $past(sec_910) : $past(prim_910)))
    else $error("9/10 read from wrong bank");
  a_read_hold: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    !RD_I |=> $stable(RDATA_O))
    else $error("Read data changed without a read");
  a_field_order: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    {PRIM_PRIO_EIGHT_O, PRIM_PRIO_SEVEN_O} == prim_78)
    else $error("7/8 fields swapped");
  a_field_order_sec78: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    {SEC_PRIO_EIGHT_O, SEC_PRIO_SEVEN_O} == sec_78)
    else $error("Secondary 7/8 fields swapped");
  a_field_order_910: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    {SEC_PRIO_TEN_O, SEC_PRIO_NINE_O} == sec_910)
    else $error("9/10 fields swapped");
  a_field_order_prim910: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    {PRIM_PRIO_TEN_O, PRIM_PRIO_NINE_O} == prim_910)
    else $error("Primary 9/10 fields swapped");
  a_zero_excl: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    PRIM_PRIO_SEVEN_O == PRIO_DISABLED
    |-> !PRIM_ENABLE_O[0] && (PRIM_BEST_O != 2'd0 || !PRIM_BEST_VALID_O))
    else $error("Zero priority selected");
  a_sec_zero_excl: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    SEC_PRIO_TEN_O == PRIO_DISABLED
    |-> !SEC_ENABLE_O[3] && (SEC_BEST_O != 2'd3 || !SEC_BEST_VALID_O))
    else $error("Zero secondary priority selected");
  a_valid_any: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    PRIM_BEST_VALID_O == (PRIM_ENABLE_O != 4'h0))
    else $error("Best valid disagrees with enables");
  a_best_nonzero: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    PRIM_BEST_VALID_O |-> prim_best_val != PRIO_DISABLED)
    else $error("Best points at a disabled input");
  a_best_rank: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    PRIM_BEST_VALID_O && PRIM_ENABLE_O[1] |-> prim_best_val <= PRIM_PRIO_EIGHT_O)
    else $error("Best not smallest");
  a_sec_best_rank: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    SEC_BEST_VALID_O && SEC_ENABLE_O[0] |-> sec_best_val <= SEC_PRIO_SEVEN_O)
    else $error("Secondary best not smallest");

  c_sec_write: cover property (@(posedge CLOCK_I) sec_wr_78);
  c_bank_read: cover property (@(posedge CLOCK_I) RD_I && hit_910 && bank_sel);
  c_none_valid: cover property (@(posedge CLOCK_I) !SEC_BEST_VALID_O);
  c_skip_zero: cover property (@(posedge CLOCK_I) PRIM_BEST_VALID_O && !PRIM_ENABLE_O[0]);
  c_bank_switch: cover property (@(posedge CLOCK_I) $changed(bank_sel));
endmodule

// ### hw/prio_regs_pkg.sv
// Package for the reference input priority register pair.
// Assumes an 8-bit microprocessor port with byte addresses.
package prio_regs_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_PRIO_7_8 = 8'h1B;
  localparam logic [7:0] ADDR_PRIO_9_10 = 8'h1C;
  localparam logic [7:0] ADDR_SOURCE_SELECT = 8'h4B;
  localparam int BANK_SEL_BIT = 4;
  // ==========================================================
  // Field layout
  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 4;
  localparam int FIELD_W = 4;
  localparam logic [3:0] PRIO_DISABLED = 4'h0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_PRIO_7_8 = 8'h98;
  localparam logic [7:0] RST_PRIO_9_10 = 8'hBA;
  localparam logic [7:0] RST_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;
  // Value returned for an address that maps to no register
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ### hw/prio_bank.sv
// One bank of priority registers (inputs 7/8 and 9/10).
// Assumes the caller gates the write strobes by bank selection.
`timescale 1ns/100ps
module prio_bank (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic wr_78_i,
  input wire logic wr_910_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] prio_78_o,
  output logic [7:0] prio_910_o
);
  import prio_regs_pkg::*;
  // ==========================================================
  // Storage
  // reset values 7/8 and 9/10
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prio_78_o <= RST_PRIO_7_8;
      prio_910_o <= RST_PRIO_9_10;
    end else begin
      if (wr_78_i) begin
        prio_78_o <= wdata_i;
      end
      if (wr_910_i) begin
        prio_910_o <= wdata_i;
      end
    end
  end
endmodule

// ### testbench/ref_input_priority_regs_tb_top.sv
// Testbench for the reference input priority register pair.
// Assumes the design package and modules are compiled before this file.
`timescale 1ns/100ps
module ref_input_priority_regs_tb_top;
  import prio_regs_pkg::*;
  logic clock_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata, src = RST_SOURCE_SELECT, d;
  logic bank_sel;
  wire [1:0][3:0][3:0] fld;
  wire [1:0][3:0] en;
  wire [1:0][1:0] best;
  wire [1:0] bv;
  logic [7:0] m [2][2] = '{'{RST_PRIO_7_8, RST_PRIO_9_10}, '{RST_PRIO_7_8, RST_PRIO_9_10}};
  logic [7:0] adr_tab [4] = '{ADDR_PRIO_7_8, ADDR_PRIO_9_10, ADDR_SOURCE_SELECT, 8'h1A};
  int error_cnt = 0, checked = 0, cyc = 0;

  ref_input_priority_regs uut (.CLOCK_I(clock_i), .SRST_I(srst_i), .ADDR_I(addr_i),
    .WR_I(wr_i), .RD_I(rd_i), .WDATA_I(wdata_i), .RDATA_O(rdata),
    .PATH_BANK_SELECT_O(bank_sel),
    .PRIM_PRIO_SEVEN_O(fld[0][0]), .PRIM_PRIO_EIGHT_O(fld[0][1]),
    .PRIM_PRIO_NINE_O(fld[0][2]), .PRIM_PRIO_TEN_O(fld[0][3]),
    .SEC_PRIO_SEVEN_O(fld[1][0]), .SEC_PRIO_EIGHT_O(fld[1][1]),
    .SEC_PRIO_NINE_O(fld[1][2]), .SEC_PRIO_TEN_O(fld[1][3]),
    .PRIM_ENABLE_O(en[0]), .SEC_ENABLE_O(en[1]), .PRIM_BEST_O(best[0]),
    .PRIM_BEST_VALID_O(bv[0]), .SEC_BEST_O(best[1]), .SEC_BEST_VALID_O(bv[1]));

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  // ==========================================================
  // Checking helpers
  function automatic logic [7:0] exp_sel(input logic [7:0] r78, input logic [7:0] r910);
    logic [3:0] f [4];
    logic [3:0] e;
    logic [3:0] bestv;
    logic [1:0] ix;
    f = '{r78[3:0], r78[7:4], r910[3:0], r910[7:4]};
    e = 4'h0;
    bestv = 4'hF;
    ix = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (f[i] != 4'h0) begin
        e[i] = 1'b1;
        if (f[i] <= bestv) begin
          bestv = f[i];
          ix = 2'(i);
        end
      end
    end
    return {e, |e, 1'b0, ix};
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk_outs();
    for (int b = 0; b < 2; b++) begin
      chk("fields_7_8", {fld[b][1], fld[b][0]}, m[b][0]);
      chk("fields_9_10", {fld[b][3], fld[b][2]}, m[b][1]);
      chk("selection", {en[b], bv[b], 1'b0, (bv[b] === 1'b1) ? best[b] : 2'b00},
          exp_sel(m[b][0], m[b][1]));
    end
    chk("bank_select", {7'h00, bank_sel}, {7'h00, src[BANK_SEL_BIT]});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    if (a == ADDR_SOURCE_SELECT) src = v;
    else if (a == ADDR_PRIO_7_8) m[src[BANK_SEL_BIT]][0] = v;
    else if (a == ADDR_PRIO_9_10) m[src[BANK_SEL_BIT]][1] = v;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hd1b65bd8));
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    chk_outs();
    for (int b = 0; b < 2; b++) begin
      wr(ADDR_SOURCE_SELECT, 8'(b << BANK_SEL_BIT));
      rd(ADDR_PRIO_7_8, d);
      chk("reset_7_8", d, RST_PRIO_7_8);
      rd(ADDR_PRIO_9_10, d);
      chk("reset_9_10", d, RST_PRIO_9_10);
    end
    wr(ADDR_SOURCE_SELECT, 8'h00);
    wr(ADDR_PRIO_7_8, 8'h00);
    wr(ADDR_PRIO_9_10, 8'h11);
    chk_outs();
    for (int n = 0; n < 60; n++) begin
      wr(adr_tab[$urandom % 4], 8'($urandom));
      chk_outs();
      rd(adr_tab[n % 4], d);
      chk("readback", d, (n % 4 == 2) ? src : (n % 4 == 3) ? 8'h00
          : m[src[BANK_SEL_BIT]][n % 4]);
    end
    // Secondary bank with every input excluded
    wr(ADDR_SOURCE_SELECT, 8'h10);
    wr(ADDR_PRIO_7_8, 8'h00);
    wr(ADDR_PRIO_9_10, 8'h00);
    chk_outs();
    // Mid-run reset brings both banks back
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    m = '{'{RST_PRIO_7_8, RST_PRIO_9_10}, '{RST_PRIO_7_8, RST_PRIO_9_10}};
    src = RST_SOURCE_SELECT;
    #1;
    chk_outs();
    chk("rdata_reset", rdata, RST_READ_DATA);
    rd(ADDR_PRIO_9_10, d);
    chk("reset_again_9_10", d, RST_PRIO_9_10);
    rd(ADDR_PRIO_7_8, d);
    chk("reset_again_7_8", d, RST_PRIO_7_8);
    final_report();
  end
endmodule
